// ==== rtl/audio_pin_pkg.sv ====
package audio_pin_pkg;

  // apb window and register byte offsets
  localparam int unsigned    APB_ADDR_W       = 8;
  localparam logic [7:0]     CTRL_OFS         = 8'h00;
  localparam logic [7:0]     GPIO_OUT_OFS     = 8'h04;
  localparam logic [7:0]     GPIO_IN_OFS      = 8'h08;
  localparam logic [7:0]     SUBCODE_OFS      = 8'h0c;
  localparam logic [7:0]     STATUS_OFS       = 8'h10;

  // reset values: zero puts every pin except the error and c flag pins in its audio default
  localparam logic [13:0]    CTRL_RST         = 14'h0000;
  localparam logic [7:0]     GPIO_OUT_RST     = 8'h00;

  // field positions inside the gpio output and subcode registers
  localparam int unsigned    GPIO_OE_LSB      = 4;
  localparam int unsigned    SUBCODE_SYNC_BIT = 8;
  localparam int unsigned    SUBCODE_BITS     = 8;

  // control register layout, msb first
  typedef struct packed {
    logic [1:0] rx_sel;      // which digital audio input feeds the receiver
    logic       flag_en;     // error and c flag pins in audio use
    logic [1:0] spdif_gpio;  // digital audio outputs taken over by gpio
    logic [1:0] sdo_gpio;    // serial data outputs taken over by gpio
    logic       mclk_sel;    // word clock 3 pin is the audio master clock
    logic [2:0] wclk_oe;     // word clock pins driven
    logic [2:0] bclk_oe;     // bit clock pins driven
  } ctrl_s;

  // what the audio core hands to the pins
  typedef struct packed {
    logic [2:0] bclk;
    logic [2:0] wclk;
    logic [1:0] sdo;
    logic [1:0] spdif;
  } core_tx_s;

  // what the pins hand back to the audio core
  typedef struct packed {
    logic [2:0] bclk;
    logic [2:0] wclk;
    logic       mclk;
    logic [1:0] sdi;
    logic       ef;
    logic       cflag;
    logic       spdif;
  } core_rx_s;

  // subcode shifter states
  typedef enum logic [0:0] {SC_IDLE, SC_SHIFT} sc_state_e;

endpackage

// ==== rtl/pin_sync3.sv ====
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] ff1_reg;  // metastable stage, read only by ff2
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;

  // three stages; a bit changes only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      level   <= '0;
    end else begin
      ff1_reg <= pin;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (ff2_reg[i] == ff3_reg[i]) begin
          level[i] <= ff3_reg[i];
        end
      end
    end
  end
endmodule

// ==== rtl/subcode_tx.sv ====
`timescale 1ns/100ps
module subcode_tx
  import audio_pin_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    rck_level,
  input  wire logic                    load,
  input  wire logic [SUBCODE_BITS-1:0] load_byte,
  input  wire logic                    load_sync,
  output logic                         sync_out,
  output logic                         data_out,
  output logic                         busy
);
  sc_state_e                 state_reg;
  logic                      rck_d_reg;   // previous filtered clock level
  logic [SUBCODE_BITS-1:0]   shift_reg;   // bits still to go, msb first
  logic [2:0]                cnt_reg;     // bit index within the byte
  logic                      rck_fall;

  // outputs move on the encoder's falling edge so its rising edge sees stable data
  assign rck_fall = rck_d_reg & ~rck_level;
  assign busy     = (state_reg == SC_SHIFT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rck_d_reg <= 1'b0;
    end else begin
      rck_d_reg <= rck_level;
    end
  end

  // byte shifter, one bit per encoder clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= SC_IDLE;
      shift_reg     <= '0;
      cnt_reg       <= '0;
      sync_out      <= 1'b0;
      data_out      <= 1'b0;
    end else begin
      unique case (state_reg)
        SC_IDLE: begin
          // first bit goes out at once: the link clock rests low,
          // so the encoder's first rise must already see it
          if (load) begin
            data_out  <= load_byte[SUBCODE_BITS-1];
            sync_out  <= load_sync;
            shift_reg <= {load_byte[SUBCODE_BITS-2:0], 1'b0};
            cnt_reg   <= '0;
            state_reg <= SC_SHIFT;
          end
        end
        SC_SHIFT: begin
          if (rck_fall) begin
            cnt_reg  <= cnt_reg + 3'd1;
            sync_out <= 1'b0;
            if (cnt_reg == 3'd7) begin
              data_out  <= 1'b0;  // line rests low between bytes
              state_reg <= SC_IDLE;
            end else begin
              data_out  <= shift_reg[SUBCODE_BITS-1];
              shift_reg <= {shift_reg[SUBCODE_BITS-2:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sc_edge_only: assert property ($changed(data_out) || $changed(sync_out) |-> $past(rck_fall) || $past(load))
    else $error("subcode output moved without an encoder clock fall");
  a_sc_sync_first: assert property (sync_out |-> busy && cnt_reg == 3'd0)
    else $error("subcode sync outside first bit of a synced byte");
  a_sc_data_msb: assert property (busy && rck_fall && cnt_reg != 3'd7 |=> data_out == $past(shift_reg[SUBCODE_BITS-1]))
    else $error("subcode data bit not taken from shifter msb");
  a_sc_idle_low: assert property (!busy |-> !data_out && !sync_out)
    else $error("subcode lines not low between bytes");
endmodule

// ==== rtl/audio_pin_logic.sv ====
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
// Function
// - bit clock pins programmable; input during reset
// - word clock pins programmable; input during reset
// - word clock 3 may take master clock
// - serial inputs feed interfaces 1 and 3
// - serial outputs default audio, else gpio
// - error flag captured for interface 1
// - c flag captured for interface 1
// - four inputs; setting picks receiver source
// - four input levels always readable as gpio
// - consumer and professional digital audio outputs
// - digital audio outputs default audio in reset
// - subcode sync high only when inserted
// - subcode shifted out serially, three lines
module audio_pin_logic (
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // apb slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [audio_pin_pkg::APB_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                           pwdata,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // audio core side
  input  wire audio_pin_pkg::core_tx_s               core_tx,
  output audio_pin_pkg::core_rx_s                    core_rx,
  // serial audio clock pins, index 0 is port 1
  input  wire logic [2:0]                            bit_clock_port_in,
  output logic      [2:0]                            bit_clock_port_out,
  output logic      [2:0]                            bit_clock_port_oe,
  input  wire logic [2:0]                            word_clock_port_in,
  output logic      [2:0]                            word_clock_port_out,
  output logic      [2:0]                            word_clock_port_oe,
  // serial data pins
  input  wire logic                                  serial_in_port1,
  input  wire logic                                  serial_in_port3,
  input  wire logic [1:0]                            serial_out_port_in,
  output logic      [1:0]                            serial_out_port_out,
  output logic      [1:0]                            serial_out_port_oe,
  // cd-dsp flags
  input  wire logic                                  cd_error_flag_in,
  input  wire logic                                  cd_c_flag_in,
  // digital audio pins, index 0 is source 1 / consumer
  input  wire logic [3:0]                            spdif_in_src,
  input  wire logic [1:0]                            spdif_out_port_in,
  output logic      [1:0]                            spdif_out_port_out,
  output logic      [1:0]                            spdif_out_port_oe,
  // subcode link
  input  wire logic                                  subcode_clk_in,
  output logic                                       subcode_sync_out,
  output logic                                       subcode_data_out
);
  import audio_pin_pkg::*;

  audio_pin_pkg::ctrl_s ctrl_reg;      // pin function control
  logic [7:0]           gpio_out_reg;  // gpio values [3:0], enables [7:4]
  logic [2:0]           bclk_sync;     // filtered pin levels
  logic [2:0]           wclk_sync;
  logic [1:0]           sin_sync;
  logic [1:0]           sout_sync;
  logic [1:0]           flag_sync;     // [0] error flag, [1] c flag
  logic [3:0]           spdif_sync;
  logic [1:0]           spdo_sync;
  logic                 rck_sync;
  logic                 sc_busy;
  logic                 sc_load;
  logic                 wr_access;     // write taken this edge
  logic                 rd_setup;      // read setup cycle
  logic [31:0]          rd_word;       // read mux
  logic                 addr_hit;      // any mapped offset

  // register decode, shared by write and read paths
  function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] a,
                                   input logic [7:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // register map, one aligned word each:
  //   control   pin functions, receiver source, clock directions
  //   gpio out  values for taken-over pins and their enables
  //   gpio in   live levels of digital audio and data out pins
  //   subcode   byte in [7:0], sync request in bit 8, write only
  //   status    bit 0 set while a subcode byte goes out

  // every outside pin is filtered before use, so a level change
  // reaches the core or a register four to five clocks late;
  // software polling the gpio input register must allow for that

  // all pins from outside come through a three stage filter
  // msb first: bit clocks, word clocks, data in 3 and 1,
  // data out pins, c flag, error flag, digital audio, subcode clock
  pin_sync3 #(.WIDTH(19)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({bit_clock_port_in, word_clock_port_in, serial_in_port3, serial_in_port1,
               serial_out_port_in, cd_c_flag_in, cd_error_flag_in, spdif_in_src,
               spdif_out_port_in, subcode_clk_in}),
    .level   ({bclk_sync, wclk_sync, sin_sync, sout_sync, flag_sync, spdif_sync,
               spdo_sync, rck_sync})
  );

  // gpio value or audio core value for one shared output pin
  function automatic logic pin_mux(input logic use_gpio,
                                   input logic gpio_val,
                                   input logic core_val);
    pin_mux = use_gpio ? gpio_val : core_val;
  endfunction

  // apb decode, one hit per mapped offset
  logic                 ctrl_hit;
  logic                 gout_hit;
  logic                 gin_hit;
  logic                 sc_hit;
  logic                 stat_hit;
  logic                 sc_stall;      // subcode write held off

  assign ctrl_hit = reg_hit(paddr, CTRL_OFS);
  assign gout_hit = reg_hit(paddr, GPIO_OUT_OFS);
  assign gin_hit  = reg_hit(paddr, GPIO_IN_OFS);
  assign sc_hit   = reg_hit(paddr, SUBCODE_OFS);
  assign stat_hit = reg_hit(paddr, STATUS_OFS);
  assign addr_hit = ctrl_hit | gout_hit | gin_hit | sc_hit | stat_hit;

  // a second subcode byte waits for the shifter rather than
  // being lost; a slow encoder stretches the access as long
  // as one byte of its clocks
  assign sc_stall  = psel & penable & pwrite & sc_hit & sc_busy;
  assign pready    = ~sc_stall;

  // unmapped offsets answer with an error, change nothing
  assign pslverr   = psel & penable & ~addr_hit;

  // writes land only on the edge where the access completes
  assign wr_access = psel & penable & pwrite & pready & addr_hit;

  // read data is captured in setup and stands for the access
  assign rd_setup  = psel & ~penable & ~pwrite;

  // a subcode write starts one byte on the link
  assign sc_load   = wr_access & sc_hit;

  // control register: pin functions and receiver source
  // reset value keeps every pin except the error and c flag pins in its audio role
  // a write turns pins around at once; software must keep
  // the far side quiet while a direction changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ctrl_s'(CTRL_RST);
    end else if (wr_access && ctrl_hit) begin
      ctrl_reg <= ctrl_s'(pwdata[$bits(ctrl_s)-1:0]);
    end
  end

  // gpio output register: values low nibble, enables high
  // only pins taken over by gpio look at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out_reg <= GPIO_OUT_RST;
    end else if (wr_access && gout_hit) begin
      gpio_out_reg <= pwdata[7:0];
    end
  end

  // read mux; subcode reads as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (ctrl_hit) begin
      rd_word = {18'h0_0000, ctrl_reg};
    end else if (gout_hit) begin
      rd_word = {24'h00_0000, gpio_out_reg};
    end else if (gin_hit) begin
      // live levels whatever the receiver source is
      rd_word = {24'h00_0000, spdo_sync, sout_sync, spdif_sync};
    end else if (stat_hit) begin
      rd_word = {31'h0000_0000, sc_busy};
    end
  end

  // read data register, loaded in the setup cycle
  // so the slave never needs a wait state on reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

  // bit and word clock pins; all inputs while reset is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_clock_port_oe   <= 3'b000;
      bit_clock_port_out  <= 3'b000;
      word_clock_port_oe  <= 3'b000;
      word_clock_port_out <= 3'b000;
    end else begin
      bit_clock_port_oe   <= ctrl_reg.bclk_oe;
      bit_clock_port_out  <= core_tx.bclk;
      // word clock 3 never drives while it brings the master clock in
      word_clock_port_oe  <= ctrl_reg.wclk_oe & {~ctrl_reg.mclk_sel, 2'b11};
      word_clock_port_out <= core_tx.wclk;
    end
  end

  // serial data outputs: audio by default, gpio when taken over
  // under gpio the enable bit decides the direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_port_oe  <= 2'b11;
      serial_out_port_out <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        serial_out_port_out[i] <= pin_mux(ctrl_reg.sdo_gpio[i], gpio_out_reg[i],
                                          core_tx.sdo[i]);
        serial_out_port_oe[i]  <= pin_mux(ctrl_reg.sdo_gpio[i],
                                          gpio_out_reg[GPIO_OE_LSB+i], 1'b1);
      end
    end
  end

  // digital audio outputs: index 0 consumer, 1 professional
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spdif_out_port_oe  <= 2'b11;
      spdif_out_port_out <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        spdif_out_port_out[i] <= pin_mux(ctrl_reg.spdif_gpio[i], gpio_out_reg[2+i],
                                         core_tx.spdif[i]);
        spdif_out_port_oe[i]  <= pin_mux(ctrl_reg.spdif_gpio[i],
                                         gpio_out_reg[GPIO_OE_LSB+2+i], 1'b1);
      end
    end
  end

  // audio core side: filtered pins, flags gated by their select
  // one more register stage keeps the core's inputs glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_rx <= '0;
    end else begin
      core_rx.bclk  <= bclk_sync;
      core_rx.wclk  <= wclk_sync;
      // master clock only when word clock 3 is in that role
      core_rx.mclk  <= ctrl_reg.mclk_sel & wclk_sync[2];
      core_rx.sdi   <= sin_sync;
      // flags belong to serial input 1 only; gpio use reads zero
      core_rx.ef    <= ctrl_reg.flag_en & flag_sync[0];
      core_rx.cflag <= ctrl_reg.flag_en & flag_sync[1];
      // all four sources stay visible as gpio meanwhile
      core_rx.spdif <= spdif_sync[ctrl_reg.rx_sel];
    end
  end

  // subcode link: the encoder owns the clock, this block
  // only listens; the filter delay limits how fast that
  // clock may run, a few pclk per half period at least
  subcode_tx u_subcode (
    .pclk      (pclk),
    .presetn   (presetn),
    .rck_level (rck_sync),
    .load      (sc_load),
    .load_byte (pwdata[SUBCODE_BITS-1:0]),
    .load_sync (pwdata[SUBCODE_SYNC_BIT]),
    .sync_out  (subcode_sync_out),
    .data_out  (subcode_data_out),
    .busy      (sc_busy)
  );

  // checks on this level
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // one completed apb access, as the master sees it
  sequence s_apb_access;
    psel && penable && pready;
  endsequence

  a_unmapped_err: assert property (s_apb_access ##0 !addr_hit |-> pslverr)
    else $error("unmapped offset answered without an error");

  a_sc_write_stall: assert property (psel && penable && pwrite && sc_hit && sc_busy |-> !pready)
    else $error("subcode write accepted while shifter busy");

  a_sdo_audio_oe: assert property (!ctrl_reg.sdo_gpio[0] |=> serial_out_port_oe[0])
    else $error("serial out not driven in audio use");

  a_spdif_audio_oe: assert property (!ctrl_reg.spdif_gpio[0] |=> spdif_out_port_oe[0])
    else $error("digital audio out not driven in audio use");

  a_wclk_mclk_in: assert property (ctrl_reg.mclk_sel |=> !word_clock_port_oe[2])
    else $error("word clock 3 driven while master clock in");

  a_flag_gated: assert property (!ctrl_reg.flag_en |=> !core_rx.ef && !core_rx.cflag)
    else $error("cd flag passed while not in audio use");

  a_bclk_follow: assert property (1'b1 |=> bit_clock_port_oe == $past(ctrl_reg.bclk_oe))
    else $error("bit clock direction not as programmed");

  a_sdi_route: assert property (1'b1 |=> core_rx.sdi == $past(sin_sync))
    else $error("serial input not routed to its interface");

  a_rx_select: assert property (1'b1 |=> core_rx.spdif == $past(spdif_sync[ctrl_reg.rx_sel]))
    else $error("receiver fed from the wrong source");

  a_gpio_in_live: assert property (rd_setup && gin_hit |=> prdata[3:0] == $past(spdif_sync))
    else $error("gpio input read not the live pin levels");

  a_spdif_route: assert property (!ctrl_reg.spdif_gpio[1] |=> spdif_out_port_out[1] == $past(core_tx.spdif[1]))
    else $error("professional output not from the core");

endmodule

// ==== verification/subcode_encoder_model.sv ====
`timescale 1ns/100ps
// channel encoder stand-in: owns the subcode clock, samples on its rise
module subcode_encoder_model (
  output logic       subcode_clk_in,
  input  wire logic  subcode_sync_out,
  input  wire logic  subcode_data_out,
  output logic [7:0] got_byte,
  output logic       got_sync
);
  // clock stands low between frames, the block never drives it
  initial begin
    subcode_clk_in = 1'b0;
    got_byte = 8'h00;
    got_sync = 1'b0;
  end
  // one frame of n link clocks at 80 ns; newest bit lands at the lsb
  task automatic frame(input int n);
    got_sync = 1'b0;
    for (int i = 0; i < n; i++) begin
      #40 subcode_clk_in = 1'b1;
      got_byte = {got_byte[6:0], subcode_data_out};
      got_sync = got_sync | subcode_sync_out;
      #40 subcode_clk_in = 1'b0;
    end
  endtask
endmodule

// ==== verification/audio_interface_pin_logic_tb.sv ====
`timescale 1ns/100ps
module audio_interface_pin_logic_tb;
  import audio_pin_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, gbyte;
  logic [31:0] pwdata, prdata, rd;
  logic        sck, syo, dao, sin1, sin3, ef, cf, gsync;
  core_tx_s    core_tx;
  core_rx_s    core_rx;
  logic [2:0]  bin, bout, boe, win, wout, woe;
  logic [1:0]  sdo, sdo_oe, spo, spo_oe;
  logic [3:0]  src;
  int          mismatches, cmp_count;
  // 250 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  audio_pin_logic i_audio_pin_logic (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_tx(core_tx), .core_rx(core_rx),
    .bit_clock_port_in(bin), .bit_clock_port_out(bout), .bit_clock_port_oe(boe),
    .word_clock_port_in(win), .word_clock_port_out(wout), .word_clock_port_oe(woe),
    .serial_in_port1(sin1), .serial_in_port3(sin3), .serial_out_port_in(2'b00),
    .serial_out_port_out(sdo), .serial_out_port_oe(sdo_oe), .cd_error_flag_in(ef),
    .cd_c_flag_in(cf), .spdif_in_src(src), .spdif_out_port_in(2'b00),
    .spdif_out_port_out(spo), .spdif_out_port_oe(spo_oe), .subcode_clk_in(sck),
    .subcode_sync_out(syo), .subcode_data_out(dao));
  subcode_encoder_model i_subcode_encoder_model (.subcode_clk_in(sck),
    .subcode_sync_out(syo), .subcode_data_out(dao), .got_byte(gbyte), .got_sync(gsync));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // apb transfer; waits on pready under a bound, read data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pin inputs cross a synchroniser; give them time to land
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  // programmed directions drive core values out
  task automatic t_direction;
    core_tx <= '{bclk: 3'b110, wclk: 3'b001, sdo: 2'b10, spdif: 2'b01};
    apb(1'b1, CTRL_OFS, {18'h0, 14'h003d});
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    check("ctrl readback", rd, 32'h0000_003d);
    settle();
    check("bclk oe", boe, 3'b101);
    check("bclk out", bout & boe, 3'b100);
    check("wclk oe", woe, 3'b111);
    check("spdif out", spo, 2'b01);
  endtask
  // serial data, flags and master clock reach the core
  task automatic t_inputs;
    sin1 <= 1'b1;
    ef <= 1'b1;
    cf <= 1'b1;
    win <= 3'b100;
    apb(1'b1, CTRL_OFS, {18'h0, 14'h0840});
    settle();
    check("sdi", core_rx.sdi, 2'b01);
    check("ef", core_rx.ef, 1'b1);
    check("cflag", core_rx.cflag, 1'b1);
    check("mclk", core_rx.mclk, 1'b1);
  endtask
  // every receiver source, gpio level read back each time
  task automatic t_rx_sel;
    for (int s = 0; s < 4; s++) begin
      src <= 4'h1 << s;
      apb(1'b1, CTRL_OFS, {18'h0, 2'(s), 12'h000});
      settle();
      check("rx src", core_rx.spdif, 1'b1);
      apb(1'b0, GPIO_IN_OFS, 32'h0000_0000);
      check("gpio in", rd[3:0], 4'h1 << s);
    end
    apb(1'b0, 8'hfc, 32'h0000_0000);
    check("unmapped err", err, 1'b1);
  endtask
  // a byte with sync, then one without
  task automatic t_subcode;
    apb(1'b1, SUBCODE_OFS, 32'h0000_01a5);
    i_subcode_encoder_model.frame(8);
    check("sub byte", gbyte, 8'ha5);
    check("sub sync", gsync, 1'b1);
    apb(1'b1, SUBCODE_OFS, 32'h0000_003c);
    i_subcode_encoder_model.frame(8);
    check("sub byte2", gbyte, 8'h3c);
    check("no sync", gsync, 1'b0);
  endtask
  // reset held 20 cycles, defaults checked inside it
  initial begin
    {presetn, psel, penable, pwrite, sin1, sin3, ef, cf} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    src = 4'h0;
    mismatches = 0;
    cmp_count = 0;
    core_tx = '0;
    bin = 3'b101;
    win = 3'b010;
    repeat (10) @(posedge pclk);
    check("bclk oe rst", boe, 3'b000);
    check("wclk oe rst", woe, 3'b000);
    check("sdo oe rst", sdo_oe, 2'b11);
    check("spdif oe rst", spo_oe, 2'b11);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("bclk in", core_rx.bclk, 3'b101);
    t_direction();
    t_inputs();
    t_rx_sel();
    t_subcode();
    results();
  end
endmodule
